/* File: common/tone_pkg.sv */
/*
 constants for the tone digit serial readout block.
 assumes a 50 MHz core clock and a front end that reports the tone pair
 as a low-group row index and a high-group column index.
*/
package tone_pkg;

    // core clock rate
    localparam int CLK_MHZ = 50;

    // steering variants
    typedef enum logic {
        STEER_EARLY,
        STEER_DELAYED
    } steer_type;

    // guard times in microseconds
    localparam int GUARD_ON_US = 40;
    localparam int GUARD_OFF_US = 40;

    // bits in one digit and pulses in one readout
    localparam int DIGIT_BITS = 4;
    localparam logic [2:0] PULSES_PER_DIGIT = 3'h4;

    // reset values
    localparam logic [3:0] DIGIT_RESET = 4'h0;
    localparam logic [2:0] COUNT_RESET = 3'h0;

    // digit code per tone pair, index {row, column}
    // rows 697/770/852/941 Hz, columns 1209/1336/1477/1633 Hz
    localparam logic [63:0] PAIR_CODE_TABLE = {
        4'h0, 4'hc, 4'ha, 4'hb,
        4'hf, 4'h9, 4'h8, 4'h7,
        4'he, 4'h6, 4'h5, 4'h4,
        4'hd, 4'h3, 4'h2, 4'h1
    };

    function automatic logic [3:0] pair_to_code(input logic [3:0] pair);
        pair_to_code = PAIR_CODE_TABLE[pair*4 +: 4];
    endfunction

endpackage

/* File: hw/tone_digit_serial_readout.sv */
/*
 digital output side of a dual-tone receiver: steering output, digit
 latch, serial shift on the acknowledge clock, cadence multiplex and
 power-down forcing.
 assumes the front end runs on ref_clk; ack_clk and power_down_in are
 pins from the host; ack_clk idles low and stands still between reads.
*/
//
// How it works
// - each tone pair maps to distinct code
// - early variant: steer high while tone present
// - delayed variant: steer high after guard time
// - four ack pulses shift out four bits
// - first rising edge captures whole digit
// - ack pin pulled low, host idles low
// - serial pin shows bits, otherwise cadence
// - power-down forces serial output low
// - power-down forces early steer low
// - power-down forces delayed steer low
// - power-down input high powers down, pulled low
// - least significant bit first, then ascending
// - data from first rise to fourth fall
// - partial read blocks new digit latch
// - extra pulses ignored until next steer rise
`timescale 1ns/1ps

module tone_digit_serial_readout
    import tone_pkg::*;
#(
    parameter steer_type VARIANT = STEER_DELAYED,
    parameter int ON_US = GUARD_ON_US,
    parameter int OFF_US = GUARD_OFF_US
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic ack_clk,
    input wire logic power_down_in,
    input wire logic pair_valid,
    input wire logic [3:0] tone_pair,
    input wire logic tone_present,
    input wire logic energy_present,
    output logic early_steer,
    output logic delayed_steer,
    output logic serial_out
);

    // guard counts, at least one cycle
    localparam int ON_CYC_RAW = ON_US * CLK_MHZ;
    localparam int OFF_CYC_RAW = OFF_US * CLK_MHZ;
    localparam int ON_CYC = (ON_CYC_RAW < 1) ? 1 : ON_CYC_RAW;
    localparam int OFF_CYC = (OFF_CYC_RAW < 1) ? 1 : OFF_CYC_RAW;
    localparam int CW = $clog2(ON_CYC + OFF_CYC + 1);
    localparam logic [CW-1:0] ON_LAST = CW'(ON_CYC - 1);
    localparam logic [CW-1:0] OFF_LAST = CW'(OFF_CYC - 1);

    logic pd_s1_q, pd_s2_q, pd_s3_q, pd_q;
    logic [CW-1:0] guard_cnt_q;
    logic dly_q;
    logic early_steer_q, delayed_steer_q, serial_q;
    logic steer_src, steer_prev_q;
    logic [3:0] digit_q, digit_d;
    logic arm_tgl_q;
    logic rst_ack_q;
    logic seq_s1_q, seq_s2_q, end_s1_q, end_s2_q, bit_s1_q, bit_s2_q;
    logic pending, window;
    // ack domain
    logic [2:0] count_q;
    logic [3:0] shift_q;
    logic bit_q, seq_q, end_seq_q;
    logic armed;

    ////////////////////////////////////////////////////////////////////
    // power-down pin: three stages, change taken when last two agree
    // pad pull-down keeps an open pin low
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pd_s1_q <= 1'b0;
            pd_s2_q <= 1'b0;
            pd_s3_q <= 1'b0;
            pd_q <= 1'b0;
        end else begin
            pd_s1_q <= power_down_in;
            pd_s2_q <= pd_s1_q;
            pd_s3_q <= pd_s2_q;
            if (pd_s2_q == pd_s3_q) begin
                pd_q <= pd_s3_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // delayed steering: tone-present and tone-absent guard times
    always_ff @(posedge ref_clk) begin
        if (reset || pd_q) begin
            guard_cnt_q <= '0;
            dly_q <= 1'b0;
        end else if (tone_present == dly_q) begin
            guard_cnt_q <= '0;
        end else if (!dly_q && guard_cnt_q == ON_LAST) begin
            guard_cnt_q <= '0;
            dly_q <= 1'b1;
        end else if (dly_q && guard_cnt_q == OFF_LAST) begin
            guard_cnt_q <= '0;
            dly_q <= 1'b0;
        end else begin
            guard_cnt_q <= guard_cnt_q + 1'b1;
        end
    end

    // the unused variant output stays low
    assign steer_src = (VARIANT == STEER_EARLY) ? tone_present : dly_q;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            early_steer_q <= 1'b0;
            delayed_steer_q <= 1'b0;
            steer_prev_q <= 1'b0;
        end else begin
            early_steer_q <= (VARIANT == STEER_EARLY) && tone_present && !pd_q;
            delayed_steer_q <= (VARIANT == STEER_DELAYED) && dly_q && !pd_q;
            steer_prev_q <= steer_src && !pd_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // digit latch and arming; frozen while a read is pending
    assign pending = (arm_tgl_q != end_s2_q);
    assign window = (seq_s2_q != end_s2_q);
    assign digit_d = pair_valid ? pair_to_code(tone_pair) : digit_q;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            digit_q <= DIGIT_RESET;
            arm_tgl_q <= end_s2_q;
        end else if (!pending && !pd_q) begin
            digit_q <= digit_d;
            if (steer_src && !steer_prev_q) begin
                arm_tgl_q <= !arm_tgl_q;
            end
        end
    end

    // reset for the ack domain, asserted while core reset is seen
    always_ff @(posedge ref_clk) begin
        rst_ack_q <= reset;
    end

    ////////////////////////////////////////////////////////////////////
    // ack domain: shift on rising edges
    // digit_q and arm_tgl_q settle no later than the ref_clk edge that raises steer, and the
    // host waits for steer, so they are read here without a synchroniser
    assign armed = (arm_tgl_q != seq_q);

    always_ff @(posedge ack_clk or posedge rst_ack_q) begin
        if (rst_ack_q) begin
            count_q <= COUNT_RESET;
            shift_q <= DIGIT_RESET;
            bit_q <= 1'b0;
            seq_q <= 1'b0;
        end else if ((count_q == COUNT_RESET || count_q == PULSES_PER_DIGIT) && armed) begin
            shift_q <= digit_q;
            bit_q <= digit_q[0];
            count_q <= 3'h1;
            seq_q <= arm_tgl_q;
        end else if (count_q != COUNT_RESET && count_q != PULSES_PER_DIGIT) begin
            bit_q <= shift_q[count_q[1:0]];
            count_q <= count_q + 3'h1;
        end
    end

    // window closes on the falling edge of the fourth pulse
    always_ff @(negedge ack_clk or posedge rst_ack_q) begin
        if (rst_ack_q) begin
            end_seq_q <= 1'b0;
        end else if (count_q == PULSES_PER_DIGIT) begin
            end_seq_q <= seq_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // crossings back into the core domain
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            seq_s1_q <= 1'b0;
            seq_s2_q <= 1'b0;
            end_s1_q <= 1'b0;
            end_s2_q <= 1'b0;
            bit_s1_q <= 1'b0;
            bit_s2_q <= 1'b0;
        end else begin
            seq_s1_q <= seq_q;
            seq_s2_q <= seq_s1_q;
            end_s1_q <= end_seq_q;
            end_s2_q <= end_s1_q;
            bit_s1_q <= bit_q;
            bit_s2_q <= bit_s1_q;
        end
    end

    // serial pin: digit bit inside the window, cadence otherwise
    // adds a few core cycles of latency behind each ack edge
    always_ff @(posedge ref_clk) begin
        if (reset || pd_q) begin
            serial_q <= 1'b0;
        end else if (window) begin
            serial_q <= bit_s2_q;
        end else begin
            serial_q <= energy_present;
        end
    end

    assign early_steer = early_steer_q;
    assign delayed_steer = delayed_steer_q;
    assign serial_out = serial_q;

    ////////////////////////////////////////////////////////////////////
    // checks
    sequence s_shift_rest;
        count_q == 3'h2 ##1 count_q == 3'h3 ##1 count_q == PULSES_PER_DIGIT;
    endsequence

    sequence s_pd_held;
        pd_q ##1 pd_q;
    endsequence

    property p_pd_serial;
        @(posedge ref_clk) disable iff (reset) s_pd_held |-> !serial_out;
    endproperty
    a_pd_serial: assert property (p_pd_serial)
        else $error("serial_out high in power-down");

    property p_pd_early;
        @(posedge ref_clk) disable iff (reset) s_pd_held |-> !early_steer;
    endproperty
    a_pd_early: assert property (p_pd_early)
        else $error("early_steer high in power-down");

    property p_pd_delayed;
        @(posedge ref_clk) disable iff (reset) s_pd_held |-> !delayed_steer;
    endproperty
    a_pd_delayed: assert property (p_pd_delayed)
        else $error("delayed_steer high in power-down");

    property p_early_follow;
        @(posedge ref_clk) disable iff (reset)
            (VARIANT == STEER_EARLY) && !pd_q |=> early_steer == $past(tone_present);
    endproperty
    a_early_follow: assert property (p_early_follow)
        else $error("early_steer does not follow tone presence");

    property p_delayed_guard;
        @(posedge ref_clk) disable iff (reset)
            $rose(dly_q) |-> $past(tone_present) && $past(guard_cnt_q) == ON_LAST;
    endproperty
    a_delayed_guard: assert property (p_delayed_guard)
        else $error("delayed steer rose before guard time");

    property p_cadence_mux;
        @(posedge ref_clk) disable iff (reset)
            !window && !pd_q |=> serial_out == $past(energy_present);
    endproperty
    a_cadence_mux: assert property (p_cadence_mux)
        else $error("serial_out not carrying cadence outside window");

    property p_hold_digit;
        @(posedge ref_clk) disable iff (reset) pending |=> $stable(digit_q);
    endproperty
    a_hold_digit: assert property (p_hold_digit)
        else $error("digit changed while read pending");

    property p_first_bit;
        @(posedge ack_clk) disable iff (rst_ack_q)
            (count_q == COUNT_RESET || count_q == PULSES_PER_DIGIT) && armed
            |=> count_q == 3'h1 && bit_q == shift_q[0] ##1 s_shift_rest;
    endproperty
    a_first_bit: assert property (p_first_bit)
        else $error("readout did not start with bit 0 and step four");

    property p_ignore_extra;
        @(posedge ack_clk) disable iff (rst_ack_q)
            count_q == PULSES_PER_DIGIT && !armed |=> count_q == PULSES_PER_DIGIT && $stable(bit_q);
    endproperty
    a_ignore_extra: assert property (p_ignore_extra)
        else $error("extra ack pulse changed output");

    property p_capture;
        @(posedge ack_clk) disable iff (rst_ack_q)
            (count_q == COUNT_RESET || count_q == PULSES_PER_DIGIT) && armed
            |=> shift_q == $past(digit_q);
    endproperty
    a_capture: assert property (p_capture)
        else $error("digit not captured on first pulse");

    property p_no_rearm;
        @(posedge ref_clk) disable iff (reset) pending |=> $stable(arm_tgl_q);
    endproperty
    a_no_rearm: assert property (p_no_rearm)
        else $error("read armed again while one is pending");

    property p_pd_sync;
        @(posedge ref_clk) disable iff (reset) pd_s2_q && pd_s3_q |=> pd_q;
    endproperty
    a_pd_sync: assert property (p_pd_sync)
        else $error("power-down not taken after stable pin");

    property p_data_mux;
        @(posedge ref_clk) disable iff (reset)
            window && !pd_q |=> serial_out == $past(bit_s2_q);
    endproperty
    a_data_mux: assert property (p_data_mux)
        else $error("serial_out not carrying digit bit inside window");

    // run lengths kept apart from the guard counter, so a wrong
    // guard count cannot hide behind its own compare
    logic [CW-1:0] on_run_q, off_run_q;

    always_ff @(posedge ref_clk) begin
        if (reset || pd_q) begin
            on_run_q <= '0;
            off_run_q <= '0;
        end else begin
            if (!tone_present) begin
                on_run_q <= '0;
            end else if (on_run_q != '1) begin
                on_run_q <= on_run_q + 1'b1;
            end
            if (tone_present) begin
                off_run_q <= '0;
            end else if (off_run_q != '1) begin
                off_run_q <= off_run_q + 1'b1;
            end
        end
    end

    property p_on_guard;
        @(posedge ref_clk) disable iff (reset) $rose(dly_q) |-> on_run_q == ON_CYC;
    endproperty
    a_on_guard: assert property (p_on_guard)
        else $error("delayed steer rose without full tone-present guard");

    // power-down clears the steer at once, so that fall is left out
    property p_off_guard;
        @(posedge ref_clk) disable iff (reset)
            $fell(dly_q) && !$past(pd_q) |-> off_run_q == OFF_CYC;
    endproperty
    a_off_guard: assert property (p_off_guard)
        else $error("delayed steer fell without full tone-absent guard");

endmodule

/* File: testbench/host_model.sv */
/*
 host model: reads a digit with acknowledge pulses on its own link clock.
 one acknowledge line serves two parts; both serial pins are sampled.
 assumes the bench calls pulses only after the steering output is high.
*/
`timescale 1ns/1ps
module host_model (
    output logic ack_clk,
    input wire logic serial_out,
    input wire logic serial_alt
);
    logic link_clk = 1'b0;
    logic run = 1'b0;

    initial ack_clk = 1'b0;

    ////////////////////////////////////////////////////////////////////
    // link clock stands still between reads; odd offset keeps it off ref edges
    initial begin
        #7.3;
        forever begin
            #15;
            if (run) link_clk = ~link_clk;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // six link periods high and low, well above the sync latency
    task automatic pulses(input int n, output logic [3:0] bits, output logic [3:0] bits_alt);
        bits = 4'h0;
        bits_alt = 4'h0;
        run = 1'b1;
        for (int i = 0; i < n; i++) begin
            @(posedge link_clk) ack_clk <= 1'b1;
            repeat (5) @(posedge link_clk);
            bits[i % 4] = serial_out;
            bits_alt[i % 4] = serial_alt;
            @(posedge link_clk) ack_clk <= 1'b0;
            repeat (5) @(posedge link_clk);
        end
        run = 1'b0;
    endtask
endmodule

/* File: testbench/tone_digit_serial_readout_bench.sv */
/*
 bench for the tone digit serial readout, delayed and early variants side
 by side on the same inputs, short guards.
 assumes host_model drives the acknowledge pin on its own link clock.
*/
`timescale 1ns/1ps
module tone_digit_serial_readout_bench;
    import tone_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic power_down_in = 1'b0;
    logic pair_valid = 1'b0;
    logic [3:0] tone_pair = 4'h0;
    logic tone_present = 1'b0;
    logic energy_present = 1'b0;
    logic ack_clk;
    logic early_steer;
    logic delayed_steer;
    logic serial_out;
    logic early_e;
    logic delayed_e;
    logic serial_e;
    logic [3:0] got;
    logic [3:0] got_e;
    int n_mismatch = 0;
    int comparisons = 0;
    // expected code per {row, col}
    localparam logic [3:0] CODES [16] = '{4'h1, 4'h2, 4'h3, 4'hd, 4'h4, 4'h5, 4'h6, 4'he,
        4'h7, 4'h8, 4'h9, 4'hf, 4'hb, 4'ha, 4'hc, 4'h0};

    always #10 ref_clk = ~ref_clk;

    tone_digit_serial_readout #(.VARIANT(STEER_DELAYED), .ON_US(1), .OFF_US(1)) uut (
        .ref_clk(ref_clk), .reset(reset), .ack_clk(ack_clk),
        .power_down_in(power_down_in), .pair_valid(pair_valid), .tone_pair(tone_pair),
        .tone_present(tone_present), .energy_present(energy_present),
        .early_steer(early_steer), .delayed_steer(delayed_steer), .serial_out(serial_out));

    // early-steering part on the same inputs and acknowledge line
    tone_digit_serial_readout #(.VARIANT(STEER_EARLY), .ON_US(1), .OFF_US(1)) uut_early (
        .ref_clk(ref_clk), .reset(reset), .ack_clk(ack_clk),
        .power_down_in(power_down_in), .pair_valid(pair_valid), .tone_pair(tone_pair),
        .tone_present(tone_present), .energy_present(energy_present),
        .early_steer(early_e), .delayed_steer(delayed_e), .serial_out(serial_e));

    host_model host (.ack_clk(ack_clk), .serial_out(serial_out), .serial_alt(serial_e));

    ////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wait_steer(input logic level);
        int i;
        for (i = 0; i < 200 && delayed_steer !== level; i++) @(posedge ref_clk);
        if (i == 200) begin
            n_mismatch++;
            $display("ERROR steer timeout");
            end_sim();
        end
    endtask

    task automatic tone_on(input logic [3:0] p);
        @(posedge ref_clk);
        tone_pair <= p;
        pair_valid <= 1'b1;
        tone_present <= 1'b1;
        @(posedge ref_clk);
        pair_valid <= 1'b0;
        repeat (40) @(posedge ref_clk);
        #1;
        check("steer early", {3'h0, delayed_steer}, 4'h0);
        check("early part steer", {2'h0, early_e, delayed_e}, 4'h2);
        wait_steer(1'b1);
    endtask

    task automatic tone_off;
        @(posedge ref_clk) tone_present <= 1'b0;
        wait_steer(1'b0);
        check("early part off", {3'h0, early_e}, 4'h0);
    endtask

    ////////////////////////////////////////////////////////////////////
    // half a read, a lost strobe, the rest of the read, then surplus pulses
    task automatic sc_partial;
        @(posedge ref_clk) energy_present <= 1'b1;
        tone_on(4'h5);
        host.pulses(2, got, got_e);
        check("first half", {2'h0, got[1:0]}, {2'h0, CODES[5][1:0]});
        check("first half early", {2'h0, got_e[1:0]}, {2'h0, CODES[5][1:0]});
        tone_off();
        tone_on(4'h0);
        host.pulses(2, got, got_e);
        check("second half", {2'h0, got[1:0]}, {2'h0, CODES[5][3:2]});
        check("second half early", {2'h0, got_e[1:0]}, {2'h0, CODES[5][3:2]});
        host.pulses(4, got, got_e);
        check("surplus pulses", got, 4'hf);
        check("surplus pulses early", got_e, 4'hf);
        tone_off();
    endtask

    // every pair; cadence level alternates so the mux is visible
    task automatic sc_digits;
        for (int p = 0; p < 16; p++) begin
            @(posedge ref_clk) energy_present <= p[0];
            // the early part is read only after the steer wait, the host's guard
            tone_on(p[3:0]);
            check("cadence before", {3'h0, serial_out}, {3'h0, p[0]});
            check("cadence before early", {3'h0, serial_e}, {3'h0, p[0]});
            host.pulses(4, got, got_e);
            check("digit", got, CODES[p]);
            check("digit early", got_e, CODES[p]);
            check("cadence after", {3'h0, serial_out}, {3'h0, p[0]});
            check("cadence after early", {3'h0, serial_e}, {3'h0, p[0]});
            tone_off();
        end
    endtask

    // last: a pending arm left behind is not a concern afterwards
    task automatic sc_power_down;
        @(posedge ref_clk) energy_present <= 1'b1;
        tone_on(4'h2);
        @(posedge ref_clk) power_down_in <= 1'b1;
        repeat (8) @(posedge ref_clk);
        #1;
        check("pd outputs", {1'b0, early_steer, delayed_steer, serial_out}, 4'h0);
        check("pd early part", {1'b0, early_e, delayed_e, serial_e}, 4'h0);
        @(posedge ref_clk) power_down_in <= 1'b0;
        tone_present <= 1'b0;
        repeat (8) @(posedge ref_clk);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        #1;
        check("reset outputs", {1'b0, early_steer, delayed_steer, serial_out}, 4'h0);
        check("reset outputs early", {1'b0, early_e, delayed_e, serial_e}, 4'h0);
        repeat (4) @(posedge ref_clk);
        sc_partial();
        sc_digits();
        sc_power_down();
        end_sim();
    end
endmodule
